// ===== shared/qsm_pkg.sv
// Constants, types and helpers shared by the dual quad serial memory front end.
// Contract
// R1 - Select high: device in standby, inputs ignored, data pins released.
// R2 - Select driven low puts the device in active mode, ready for an instruction.
// R3 - No instruction is accepted before a falling select edge seen after reset.
// R4 - Single-line mode samples input data on line 0 at rising clock edges.
// R5 - Quad mode uses all four data lines in both directions.
// R6 - Protect enable set and protect pin low: status register write ignored.
// R7 - Status protect pin acts only in single-line mode; in quad it carries data.
// R8 - Host or board always drives the protect line; no internal pull exists.
// R9 - SDR: command, address, write data on rising edges; read data on falling.
// R10 - DDR: command on rising edges only; address and write data on both edges.
// R11 - DDR: read data driven on both clock edges.
// R12 - Clock mode 3 (idle high) is supported for SDR transfers only.
// R13 - Quad transfers run up to 100 MHz SDR and 50 MHz DDR; the oversampled link here runs far below both rates.
// R14 - Two devices together move eight-bit wide data per transfer step.
// R15 - Uncorrectable error during a read drives the active-low interrupt low.
// R16 - Reset low holds the device in reset with pins released.
// R17 - One reset input resets both devices at the same time.
// R18 - Three hardware protect inputs size the array region that rejects writes.
// R19 - Hardware protect inputs have pull-downs; unconnected reads low.
// R20 - Top/bottom input selects at which array end the hardware region begins.
// R21 - Software protection uses top/bottom flag plus three-bit field in status.
// R22 - Top/bottom input has a pull-down; unconnected reads low.
// R23 - Writes to a hardware or software protected address leave the array unchanged.
`default_nettype none
package qsm_pkg;
    localparam int DEVS      = 2;
    localparam int NIB       = 4;
    localparam int MEM_DEPTH = 256;
    localparam int REGION_LSB = 5;

    localparam logic [7:0] CMD_WRSR  = 8'h01;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam logic [7:0] CMD_READ  = 8'h03;
    localparam logic [7:0] CMD_RDSR  = 8'h05;

    localparam logic [7:0] SR_RESET  = 8'h00;
    localparam int         SR_SRWD   = 7;
    localparam int         SR_TB     = 5;
    localparam int         SR_BP_LSB = 2;

    localparam int         CFG_SIZE_LSB  = 0;
    localparam int         CFG_TB        = 3;
    localparam int         CFG_QUAD      = 4;
    localparam int         CFG_DDR       = 5;
    localparam int         CFG_FAULT_LSB = 6;
    localparam logic [7:0] CFG_RESET     = 8'h00;

    localparam logic [5:0] PIN_RESET = 6'h3F;
    localparam logic [2:0] WARM_DONE = 3'h5;

    localparam int SDR_MAX_MHZ = 100;
    localparam int DDR_MAX_MHZ = 50;
    localparam int SYS_CLK_MHZ = 100;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CMD, ST_ADDR, ST_WRITE, ST_WRSR, ST_READ, ST_SKIP
    } qsm_state_t;

    function automatic logic qsm_in_region(input logic [7:0] addr,
                                           input logic [2:0] code,
                                           input logic       top);
        logic [3:0] sum;
        sum = {1'b0, addr[7:REGION_LSB]} + {1'b0, code};
        if (code == 3'h0)
        begin
            return 1'b0;
        end
        return top ? (sum >= 4'h8) : (addr[7:REGION_LSB] < code);
    endfunction : qsm_in_region
endpackage : qsm_pkg
`default_nettype wire

// ===== shared/qsm_pin_if.sv
// Synchronised pin view of one serial device, passed from sampler to engine.
`default_nettype none
interface qsm_pin_if;
    logic       sel_n;
    logic       sel_fall;
    logic       clk_lvl;
    logic       clk_rise;
    logic       clk_fall;
    logic [3:0] io;

    modport src (output sel_n, sel_fall, clk_lvl, clk_rise, clk_fall, io);
    modport dst (input  sel_n, sel_fall, clk_lvl, clk_rise, clk_fall, io);
endinterface : qsm_pin_if
`default_nettype wire

// ===== design/qsm_pin_sync.sv
// Three-stage sampler and edge finder for one device's select, clock and data.
`default_nettype none
module qsm_pin_sync
    import qsm_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       raw_sel_n,
    input  wire logic       raw_clk,
    input  wire logic [3:0] raw_io,
    qsm_pin_if.src          pins
);
    logic [5:0] s1_ff;
    logic [5:0] s2_ff;
    logic [5:0] s3_ff;
    logic [5:0] flt_ff;
    logic [5:0] prv_ff;
    logic [2:0] warm_ff;

    wire logic [5:0] raw     = {raw_sel_n, raw_clk, raw_io};
    wire logic [5:0] agree   = ~(s2_ff ^ s3_ff);
    wire logic [5:0] nxt_flt = (agree & s2_ff) | (~agree & flt_ff);
    wire logic       warm    = (warm_ff == WARM_DONE);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            s1_ff   <= PIN_RESET;
            s2_ff   <= PIN_RESET;
            s3_ff   <= PIN_RESET;
            flt_ff  <= PIN_RESET;
            prv_ff  <= PIN_RESET;
            warm_ff <= 3'h0;
        end
        else
        begin
            s1_ff   <= raw;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            flt_ff  <= nxt_flt;
            prv_ff  <= flt_ff;
            warm_ff <= warm ? warm_ff : 3'(warm_ff + 3'h1);
        end
    end

    // A select held low through reset is not a falling edge.
    assign pins.sel_n    = flt_ff[5];
    assign pins.sel_fall = warm & prv_ff[5] & ~flt_ff[5]; // see R3
    assign pins.clk_lvl  = flt_ff[4];
    assign pins.clk_rise = warm & ~prv_ff[4] & flt_ff[4];
    assign pins.clk_fall = warm & prv_ff[4] & ~flt_ff[4];
    assign pins.io       = flt_ff[3:0];
endmodule : qsm_pin_sync
`default_nettype wire

// ===== design/qsm_dual_mram_top.sv
// Two independent quad serial memory devices behind one shared reset.
`default_nettype none
module qsm_dual_mram_top
    import qsm_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       select_n_dev_a,
    input  wire logic       select_n_dev_b,
    input  wire logic       serial_clock_dev_a,
    input  wire logic       serial_clock_dev_b,
    input  wire logic [7:0] io_in,
    output wire logic [7:0] io_out,
    output wire logic [7:0] io_oe_n,
    output wire logic       ecc_fail_irq_n_dev_a,
    output wire logic       ecc_fail_irq_n_dev_b,
    input  wire logic       four_line_mode,
    input  wire logic       ddr_mode,
    input  wire logic [2:0] hw_protect_size,
    input  wire logic       hw_protect_top_bottom,
    input  wire logic [1:0] ecc_fault_inject
);

    // ------------------------------------------------------------
    // Configuration pin sampling
    // ------------------------------------------------------------

    logic [7:0] c1_ff;
    logic [7:0] c2_ff;
    logic [7:0] c3_ff;
    logic [7:0] cfg_ff;

    wire logic [7:0] cfg_raw = {ecc_fault_inject, ddr_mode, four_line_mode,
                                hw_protect_top_bottom, hw_protect_size};
    wire logic [7:0] cfg_agr = ~(c2_ff ^ c3_ff);
    wire logic [7:0] nxt_cfg = (cfg_agr & c2_ff) | (~cfg_agr & cfg_ff);

    // Pad pull-downs keep floating protect pins low; logic sees plain levels.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            c1_ff  <= CFG_RESET;
            c2_ff  <= CFG_RESET;
            c3_ff  <= CFG_RESET;
            cfg_ff <= CFG_RESET; // see R19 R22
        end
        else
        begin
            c1_ff  <= cfg_raw;
            c2_ff  <= c1_ff;
            c3_ff  <= c2_ff;
            cfg_ff <= nxt_cfg;
        end
    end

    wire logic       quad    = cfg_ff[CFG_QUAD];
    wire logic       ddr_req = cfg_ff[CFG_DDR];
    wire logic [2:0] hw_size = cfg_ff[CFG_SIZE_LSB +: 3];
    wire logic       hw_top  = cfg_ff[CFG_TB];

    wire logic [DEVS-1:0] sel_raw = {select_n_dev_b, select_n_dev_a};
    wire logic [DEVS-1:0] clk_raw = {serial_clock_dev_b, serial_clock_dev_a};

    wire logic [3:0] dout  [DEVS];
    wire logic [3:0] doe_n [DEVS];
    wire logic       dirq  [DEVS];

    // ------------------------------------------------------------
    // Per-device serial engine
    // ------------------------------------------------------------

    genvar g;
    generate
        for (g = 0; g < DEVS; g++)
        begin : dev
            qsm_pin_if pin ();

            // The link clock is oversampled, so the usable serial rate is a
            // fraction of the system clock, well below the pin maximum.
            qsm_pin_sync u_sync ( // see R13
                .sys_clk   (sys_clk),
                .rst_n     (rst_n),
                .raw_sel_n (sel_raw[g]),
                .raw_clk   (clk_raw[g]),
                .raw_io    (io_in[g*NIB +: NIB]),
                .pins      (pin)
            );

            logic [7:0] mem [MEM_DEPTH];
            qsm_state_t st_ff;
            qsm_state_t nxt_st;
            logic [7:0] sh_ff;
            logic [2:0] cnt_ff;
            logic [7:0] addr_ff;
            logic [7:0] cmd_ff;
            logic [7:0] sr_ff;
            logic [7:0] ob_ff;
            logic [3:0] out_ff;
            logic [3:0] oe_n_ff;
            logic       irq_n_ff;
            logic       mode3_ff;

            // Mode 3 (clock idle high at select fall) forces SDR timing.
            wire logic ddr_eff = ddr_req & ~mode3_ff; // see R12

            wire logic rx_st = (st_ff == ST_CMD) || (st_ff == ST_ADDR)
                            || (st_ff == ST_WRITE) || (st_ff == ST_WRSR);
            wire logic in_cmd = (st_ff == ST_CMD);

            // Commands take rising edges only; later phases take both in DDR.
            wire logic smp = rx_st & (pin.clk_rise
                           | (pin.clk_fall & ddr_eff & ~in_cmd)); // see R9 R10

            wire logic drv = (st_ff == ST_READ)
                           & (pin.clk_fall
                           | (pin.clk_rise & ddr_eff)); // see R9 R11

            wire logic last = quad ? (cnt_ff == 3'h1) : (cnt_ff == 3'h7);

            wire logic [7:0] nxt_sh = quad ? {sh_ff[3:0], pin.io}
                                           : {sh_ff[6:0], pin.io[0]}; // see R4 R5

            wire logic byte_done = smp & last;
            wire logic step      = smp | drv;
            wire logic restart   = pin.sel_n | pin.sel_fall;

            wire logic [2:0] nxt_cnt = restart ? 3'h0
                                     : !step   ? cnt_ff
                                     : last    ? 3'h0
                                     : 3'(cnt_ff + 3'h1);

            wire logic is_rdsr = (cmd_ff == CMD_RDSR);
            wire logic first   = (cnt_ff == 3'h0);
            wire logic [7:0] src  = is_rdsr ? sr_ff : mem[addr_ff];
            wire logic [7:0] send = first ? src : ob_ff;

            wire logic [7:0] nxt_ob = quad ? {send[3:0], 4'h0}
                                           : {send[6:0], 1'b0};

            // Protect pin is only a protect input on the single-line port,
            // and is read as driven since no pull holds it.
            wire logic wp_low  = ~pin.io[2] & ~quad; // see R7 R8
            wire logic sr_lock = sr_ff[SR_SRWD] & wp_low; // see R6

            wire logic hw_prot = qsm_in_region(addr_ff, hw_size,
                                               hw_top); // see R18 R20
            wire logic sw_prot = qsm_in_region(addr_ff,
                                    sr_ff[SR_BP_LSB +: 3],
                                    sr_ff[SR_TB]); // see R21

            wire logic wr_byte = (st_ff == ST_WRITE) & byte_done;
            wire logic wr_ok   = wr_byte & ~hw_prot & ~sw_prot; // see R23

            wire logic fault = cfg_ff[CFG_FAULT_LSB + g];

            wire qsm_state_t dec_st =
                (nxt_sh == CMD_RDSR)  ? ST_READ
              : (nxt_sh == CMD_READ)  ? ST_ADDR
              : (nxt_sh == CMD_WRITE) ? ST_ADDR
              : (nxt_sh == CMD_WRSR)  ? ST_WRSR
              :                         ST_SKIP;

            wire qsm_state_t addr_st = (cmd_ff == CMD_READ) ? ST_READ
                                                            : ST_WRITE;

            wire logic addr_inc = wr_byte
                                | (drv & last & ~is_rdsr);

            always_comb
            begin
                nxt_st = st_ff;
                unique case (st_ff)
                    ST_CMD:
                    begin
                        if (byte_done)
                        begin
                            nxt_st = dec_st;
                        end
                    end
                    ST_ADDR:
                    begin
                        if (byte_done)
                        begin
                            nxt_st = addr_st;
                        end
                    end
                    ST_WRSR:
                    begin
                        if (byte_done)
                        begin
                            nxt_st = ST_SKIP;
                        end
                    end
                    ST_IDLE, ST_WRITE, ST_READ, ST_SKIP:
                    begin
                        nxt_st = st_ff;
                    end
                endcase
                if (pin.sel_n)
                begin
                    nxt_st = ST_IDLE; // see R1
                end
                else if (pin.sel_fall)
                begin
                    nxt_st = ST_CMD; // see R2 R3
                end
            end

            // Reset is shared by both engines, so they leave it together.
            always_ff @(posedge sys_clk)
            begin
                if (!rst_n)
                begin
                    st_ff  <= ST_IDLE; // see R16 R17
                    cnt_ff <= 3'h0;
                    sh_ff  <= 8'h00;
                end
                else
                begin
                    st_ff  <= nxt_st;
                    cnt_ff <= nxt_cnt;
                    sh_ff  <= smp ? nxt_sh : sh_ff;
                end
            end

            always_ff @(posedge sys_clk)
            begin
                if (!rst_n)
                begin
                    cmd_ff  <= 8'h00;
                    addr_ff <= 8'h00;
                end
                else
                begin
                    if (in_cmd & byte_done)
                    begin
                        cmd_ff <= nxt_sh;
                    end
                    if ((st_ff == ST_ADDR) & byte_done)
                    begin
                        addr_ff <= nxt_sh;
                    end
                    else if (addr_inc)
                    begin
                        addr_ff <= 8'(addr_ff + 8'h01);
                    end
                end
            end

            always_ff @(posedge sys_clk)
            begin
                if (!rst_n)
                begin
                    sr_ff    <= SR_RESET;
                    mode3_ff <= 1'b0;
                    ob_ff    <= 8'h00;
                end
                else
                begin
                    if ((st_ff == ST_WRSR) & byte_done & ~sr_lock)
                    begin
                        sr_ff <= nxt_sh; // see R6
                    end
                    if (pin.sel_fall)
                    begin
                        mode3_ff <= pin.clk_lvl; // see R12
                    end
                    if (drv)
                    begin
                        ob_ff <= nxt_ob;
                    end
                end
            end

            // The array itself is not cleared by reset; it is non-volatile.
            always_ff @(posedge sys_clk)
            begin
                if (wr_ok)
                begin
                    mem[addr_ff] <= nxt_sh; // see R23
                end
            end

            always_ff @(posedge sys_clk)
            begin
                if (!rst_n)
                begin
                    out_ff  <= 4'h0;
                    oe_n_ff <= 4'hF; // see R16
                end
                else if (pin.sel_n || st_ff != ST_READ)
                begin
                    oe_n_ff <= 4'hF; // see R1
                end
                else if (drv)
                begin
                    out_ff  <= quad ? send[7:4]
                                    : {2'b00, send[7], 1'b0}; // see R5
                    oe_n_ff <= quad ? 4'h0 : 4'hD;
                end
            end

            // A fault seen while the next select falls still wins.
            always_ff @(posedge sys_clk)
            begin
                if (!rst_n)
                begin
                    irq_n_ff <= 1'b1;
                end
                else if (drv & first & fault & ~is_rdsr)
                begin
                    irq_n_ff <= 1'b0; // see R15
                end
                else if (pin.sel_fall)
                begin
                    irq_n_ff <= 1'b1;
                end
            end

            assign dout[g]  = out_ff;
            assign doe_n[g] = oe_n_ff;
            assign dirq[g]  = irq_n_ff;
        end
    endgenerate

    // ------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------

    // Device A owns lines 0 to 3 and device B lines 4 to 7.
    assign io_out  = {dout[1], dout[0]}; // see R14
    assign io_oe_n = {doe_n[1], doe_n[0]};
    assign ecc_fail_irq_n_dev_a = dirq[0];
    assign ecc_fail_irq_n_dev_b = dirq[1];

endmodule : qsm_dual_mram_top
`default_nettype wire

// ===== test/qsm_host_model.sv
// Behavioural two-channel serial host that drives both memory devices.
`default_nettype none
module qsm_host_model
    import qsm_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       quad,
    input  wire logic [7:0] io,
    output var  logic [1:0] sel_n,
    output var  logic [1:0] sclk,
    output var  logic [7:0] drv,
    output var  logic [7:0] en
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // Frame and byte transfer
    // ---------------------------------------------------------------
    logic [1:0] wp = 2'b11;
    initial
    begin
        sel_n = 2'b11;
        sclk  = 2'b00;
        drv   = 8'h00;
        en    = 8'h00;
    end
    task automatic half(input int d);
        repeat (4) @(posedge sys_clk);
    endtask : half
    task automatic open_frame(input int d);
        sel_n[d] <= 1'b0;
        half(d);
    endtask : open_frame
    task automatic close_frame(input int d);
        half(d);
        sel_n[d] <= 1'b1;
        en[d*4 +: 4] <= 4'h0;
        repeat (8) @(posedge sys_clk);
    endtask : close_frame
    task automatic byte_io(input int d, input logic [7:0] tx,
                           input bit rd, output logic [7:0] rx);
        logic [7:0] sh;
        rx = 8'h00;
        for (int i = quad ? 4 : 7; i >= 0; i -= quad ? 4 : 1)
        begin
            sh = tx >> i;
            drv[d*4 +: 4] <= quad ? sh[3:0]
                             : {1'b0, wp[d], 1'b0, sh[0]};
            en[d*4 +: 4] <= rd ? {1'b0, !quad, 2'b00}
                            : (quad ? 4'hF : 4'h5);
            half(d);
            sclk[d] <= 1'b1;
            half(d);
            rx = quad ? {rx[3:0], io[d*4 +: 4]} : {rx[6:0], io[d*4+1]};
            sclk[d] <= 1'b0;
        end
    endtask : byte_io
endmodule : qsm_host_model
`default_nettype wire

// ===== test/qsm_dual_mram_sva.sv
// Concurrent checks on the pins of the dual serial memory front end.
`default_nettype none
module qsm_dual_mram_sva
    import qsm_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       select_n_dev_a,
    input wire logic       select_n_dev_b,
    input wire logic       serial_clock_dev_a,
    input wire logic [7:0] io_out,
    input wire logic [7:0] io_oe_n,
    input wire logic       ecc_fail_irq_n_dev_a,
    input wire logic       ecc_fail_irq_n_dev_b,
    input wire logic       four_line_mode,
    input wire logic [1:0] ecc_fault_inject
);
    // ---------------------------------------------------------------
    // Pin behaviour
    // ---------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    rst_pins_a: assert property ($rose(rst_n) |-> io_oe_n == 8'hFF)
        else $error("pins driven after reset");
    rst_both_a: assert property ($rose(rst_n) |->
        ecc_fail_irq_n_dev_a && ecc_fail_irq_n_dev_b)
        else $error("interrupt low after reset");
    idle_a_a: assert property (select_n_dev_a [*8] |->
        io_oe_n[3:0] == 4'hF) else $error("device A drives while idle");
    idle_b_a: assert property (select_n_dev_b [*8] |->
        io_oe_n[7:4] == 4'hF) else $error("device B drives while idle");
    single_oe_a: assert property (!four_line_mode [*8] |->
        io_oe_n[3:0] inside {4'hF, 4'hD})
        else $error("wrong line driven in single mode");
    quad_oe_a: assert property (four_line_mode [*8] |->
        io_oe_n[3:0] inside {4'hF, 4'h0})
        else $error("partial nibble driven in quad mode");
    out_edge_a: assert property (!io_oe_n[1] &&
        $past(io_oe_n[1]) == 1'b0 && $changed(io_out[1]) |->
        $past(serial_clock_dev_a, 3) == 1'b0)
        else $error("read data moved away from falling edge");
    irq_cause_a: assert property ($fell(ecc_fail_irq_n_dev_a) |->
        $past(ecc_fault_inject[0], 4))
        else $error("interrupt without fault");
    irq_hold_a: assert property ($rose(ecc_fail_irq_n_dev_a) |->
        $past(select_n_dev_a, 2) == 1'b0)
        else $error("irq cleared outside frame");
    cover property ($fell(io_oe_n[0]));
    cover property ($fell(io_oe_n[1]) && !four_line_mode);
    cover property ($fell(ecc_fail_irq_n_dev_a));
endmodule : qsm_dual_mram_sva
bind qsm_dual_mram_top qsm_dual_mram_sva qsm_dual_mram_sva_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .select_n_dev_a(select_n_dev_a),
    .select_n_dev_b(select_n_dev_b), .serial_clock_dev_a(serial_clock_dev_a),
    .io_out(io_out), .io_oe_n(io_oe_n),
    .ecc_fail_irq_n_dev_a(ecc_fail_irq_n_dev_a),
    .ecc_fail_irq_n_dev_b(ecc_fail_irq_n_dev_b),
    .four_line_mode(four_line_mode), .ecc_fault_inject(ecc_fault_inject));
`default_nettype wire

// ===== test/qsm_dual_mram_top_test.sv
// Self-checking bench for the dual serial memory front end.
`default_nettype none
module qsm_dual_mram_top_test
    import qsm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // Wiring, models and checks
    // ---------------------------------------------------------------
    logic       sys_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       four_line_mode = 1'b0;
    logic [2:0] hw_size = 3'h0;
    logic       hw_top = 1'b0;
    logic [1:0] inject = 2'h0;
    logic [1:0] sel_n, sclk, irq_n;
    logic [7:0] io_in, io_out, io_oe_n, drv, en, junk = 8'h00;
    logic [7:0] exp_mem [2][256];
    logic [7:0] exp_sr [2] = '{8'h00, 8'h00};
    logic [7:0] wbuf [2][256];
    logic [7:0] rbuf [2][256];
    int         bad_count = 0;
    int         comparisons = 0;
    bit         seen_b;
    always #5 sys_clk = ~sys_clk;
    // Released lines toggle so a stale level can never pass as data.
    always @(posedge sys_clk) junk <= ~junk;
    always @(posedge sys_clk) if (io_oe_n[7:4] != 4'hF) seen_b <= 1'b1;
    assign io_in = (~io_oe_n & io_out) | (io_oe_n & en & drv)
                 | (io_oe_n & ~en & junk);
    qsm_dual_mram_top qsm_dual_mram_top_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .select_n_dev_a(sel_n[0]),
        .select_n_dev_b(sel_n[1]), .serial_clock_dev_a(sclk[0]),
        .serial_clock_dev_b(sclk[1]), .io_in(io_in), .io_out(io_out),
        .io_oe_n(io_oe_n), .ecc_fail_irq_n_dev_a(irq_n[0]),
        .ecc_fail_irq_n_dev_b(irq_n[1]), .four_line_mode(four_line_mode),
        .ddr_mode(1'b0), .hw_protect_size(hw_size),
        .hw_protect_top_bottom(hw_top), .ecc_fault_inject(inject));
    qsm_host_model qsm_host_model_inst (
        .sys_clk(sys_clk), .quad(four_line_mode), .io(io_in),
        .sel_n(sel_n), .sclk(sclk), .drv(drv), .en(en));
    task automatic check(input logic [7:0] got, exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask : check
    function automatic bit prot(input int a, input logic [2:0] c,
                                input logic t);
        return c != 3'h0 && (t ? a >= 256 - 32 * c : a < 32 * c);
    endfunction : prot
    task automatic frame(input int d, input logic [7:0] op, a, input int n);
        logic [7:0] r;
        bit         rd;
        rd = op == CMD_READ || op == CMD_RDSR;
        qsm_host_model_inst.open_frame(d);
        qsm_host_model_inst.byte_io(d, op, 1'b0, r);
        if (op == CMD_READ || op == CMD_WRITE)
            qsm_host_model_inst.byte_io(d, a, 1'b0, r);
        for (int i = 0; i < n; i++)
            qsm_host_model_inst.byte_io(d, wbuf[d][i], rd, rbuf[d][i]);
        qsm_host_model_inst.close_frame(d);
        for (int i = 0; i < n; i++)
        begin
            int k;
            k = (a + i) % 256;
            if (op == CMD_WRITE && !prot(k, hw_size, hw_top)
                && !prot(k, exp_sr[d][4:2], exp_sr[d][5]))
                exp_mem[d][k] = wbuf[d][i];
            if (op == CMD_READ)
                check(rbuf[d][i], exp_mem[d][k], "array");
        end
        if (op == CMD_WRSR && !(exp_sr[d][7] && !four_line_mode
            && !qsm_host_model_inst.wp[d]))
            exp_sr[d] = wbuf[d][0];
        if (op == CMD_RDSR)
            check(rbuf[d][0], exp_sr[d], "status");
    endtask : frame
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        test_done();
    end
    initial
    begin
        logic [7:0] r;
        void'($urandom(48957));
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        check(io_oe_n, 8'hFF, "pins after reset");
        check({6'h0, irq_n}, 8'h03, "irq after reset");
        rst_n <= 1'b0;
        qsm_host_model_inst.sel_n[1] <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (12) @(posedge sys_clk);
        seen_b = 1'b0;
        qsm_host_model_inst.byte_io(1, CMD_RDSR, 1'b0, r);
        qsm_host_model_inst.byte_io(1, 8'h00, 1'b1, r);
        qsm_host_model_inst.close_frame(1);
        check({7'h0, seen_b}, 8'h00, "early frame");
        $display("test reset done");
        four_line_mode <= 1'b1;
        repeat (8) @(posedge sys_clk);
        for (int i = 0; i < 512; i++)
            wbuf[i % 2][i / 2] = 8'($urandom);
        for (int p = 0; p < 2; p++)
            fork
                frame(0, p ? CMD_READ : CMD_WRITE, 8'h00, 256);
                frame(1, p ? CMD_READ : CMD_WRITE, 8'h00, 256);
            join
        $display("test quad fill done");
        for (int k = 0; k < 8; k++)
        begin
            four_line_mode <= k == 2 || (k > 2 && $urandom_range(1) == 1);
            qsm_host_model_inst.wp <= k == 1 ? 2'b00
                                      : (k == 0 ? 2'b11 : 2'($urandom));
            hw_size <= 3'($urandom);
            hw_top <= 1'($urandom);
            repeat (8) @(posedge sys_clk);
            for (int d = 0; d < 2; d++)
            begin
                wbuf[d][0] = k == 0 ? 8'h80 : 8'($urandom) & 8'hBC;
                frame(d, CMD_WRSR, 8'h00, 1);
                frame(d, CMD_RDSR, 8'h00, 1);
                for (int i = 0; i < 4; i++)
                    wbuf[d][i] = 8'($urandom);
                r = k == 0 ? 8'hFE : 8'($urandom);
                frame(d, CMD_WRITE, r, 4);
                frame(d, CMD_READ, r, 4);
            end
        end
        $display("test protect done");
        inject <= 2'b01;
        repeat (8) @(posedge sys_clk);
        frame(0, CMD_READ, 8'h10, 2);
        check({6'h0, irq_n}, 8'h02, "irq on fault");
        inject <= 2'b00;
        repeat (8) @(posedge sys_clk);
        frame(0, CMD_READ, 8'h10, 2);
        check({6'h0, irq_n}, 8'h03, "irq cleared");
        $display("test ecc done");
        test_done();
    end
endmodule : qsm_dual_mram_top_test
`default_nettype wire
